// ### pio_pkg.sv
/*
  Package for the three-port parallel I/O block: register addresses, reset values,
  carrier pin map, carrier timing and the packed carriers of the CPU bus.
  Assumes an 8-bit internal special-function bus with one-cycle strobes.
*/
// Summary of operation
// - Three bit-addressable port registers at 0x80/0x90/0xA0
// - Enabled peripheral owns its pin, not GPIO
// - Per-pin switchable pull-up, all enabled after reset
// - Pull-up off makes pin open-drain
// - Latch captures bus on write-to-latch strobe
// - Read-latch returns stored latch contents
// - Read-pin returns external pin levels
// - Instruction type picks latch or pin source
// - Latch 0 drives low, 1 pulls high
// - Open-drain with latch 1 floats
// - Modulated pin is latch XOR carrier
// - Global enable bit gates all modulation
// - Eight selectable carrier pins, register 0x9F
// - Carrier select bit to pin map, reset 0
// - Pull-up disables at 0xB2-0xB4, byte only
// - Set bit disables pull-up, reset 0
// - Latches reset 1, unused port2 bits read 1
package pio_pkg;
  localparam logic [7:0] PIO_ADDR_PORT0 = 8'h80;
  localparam logic [7:0] PIO_ADDR_PORT1 = 8'h90;
  localparam logic [7:0] PIO_ADDR_CARRIER_SEL = 8'h9f;
  localparam logic [7:0] PIO_ADDR_PORT2 = 8'ha0;
  localparam logic [7:0] PIO_ADDR_PU0 = 8'hb2;
  localparam logic [7:0] PIO_ADDR_PU1 = 8'hb3;
  localparam logic [7:0] PIO_ADDR_PU2 = 8'hb4;
  // Reset values
  localparam logic [7:0] PIO_RST_PORT = 8'hff;
  localparam logic [7:0] PIO_RST_CFG = 8'h00;
  localparam logic [7:0] PIO_PORT2_UNUSED = 8'hfc;
  localparam int PIO_PORT2_BITS = 2;
  // Carrier select bit positions (bit 7 down to 0)
  localparam int PIO_CSEL_P1_6 = 7;
  localparam int PIO_CSEL_P1_5 = 6;
  localparam int PIO_CSEL_P1_4 = 5;
  localparam int PIO_CSEL_P1_1 = 4;
  localparam int PIO_CSEL_P0_2 = 3;
  localparam int PIO_CSEL_P0_7 = 2;
  localparam int PIO_CSEL_P0_5 = 1;
  localparam int PIO_CSEL_P0_3 = 0;
  // Carrier timing: half period in cycles, rounded down
  localparam int PIO_CLK_HZ = 100_000_000;
  localparam int PIO_CARRIER_HZ = 38_000;
  localparam int PIO_HALF_CYCLES = PIO_CLK_HZ / (2 * PIO_CARRIER_HZ);
  // Bus request from the CPU side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_byte;
    logic wr_bit;
    logic [2:0] bit_sel;
    logic rd;
    logic rd_latch;
  } pio_bus_req_t;
  // One port's pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu_en;
  } pio_pad_t;
endpackage : pio_pkg

// ### pio_ports.sv
/*
  Three 8-bit parallel ports: latches, read-latch/read-pin paths, pull-up control
  and carrier modulation.

  What the module holds:
  - One latch byte per port. Ports 0 and 1 have eight pins, port 2 has two; the
    six spare latch bits of port 2 are forced high so they always read as set.
  - The carrier select byte and the three pull-up disable bytes. These accept
    byte writes only; a bit write aimed at them is ignored.
  - A fixed divider that makes the carrier square wave, and the XOR of that wave
    onto the eight pins that the select byte may pick.
  - The pad controls of every pin and the registered read data.

  Pad encoding per pin:
  - oe high sinks the pin low; nothing in this block ever drives a pin high.
  - pu_en high switches the weak pull-up on. It is dropped while the pin sinks,
    so the pull-up never fights the low driver.
  - With oe low and pu_en low the pin floats and needs an outside pull-up.
  - out is kept at zero for every pin.

  What it assumes of its surroundings:
  - Pin inputs are already synchronous to ref_clk.
  - The pad resolves out/oe/pu_en: strong drive when oe, weak pull-up when pu_en.
  - Bus strobes last one cycle and the CPU decoder picks read-latch for
    read-modify-write instructions and read-pin for the others.
  - The global carrier enable comes from a configuration register elsewhere.
  - A peripheral that owns a pin is enabled by logic outside this block.
*/
`timescale 1ns/10ps
module pio_ports
  import pio_pkg::*;
#(
  parameter int HALF_CYCLES = PIO_HALF_CYCLES
) (
  // Clock and asynchronous reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Internal special-function bus of the CPU
  input wire pio_bus_req_t bus,
  output logic [7:0] rdata,
  // Global carrier enable, held in a configuration register outside
  input wire logic carrier_global_enable,
  // Peripheral ownership and peripheral levels, one bit per pin
  input wire logic [7:0] periph_own_p0,
  input wire logic [7:0] periph_own_p1,
  input wire logic [1:0] periph_own_p2,
  input wire logic [7:0] periph_out_p0,
  input wire logic [7:0] periph_out_p1,
  input wire logic [1:0] periph_out_p2,
  // Resolved levels seen at the pins
  input wire logic [7:0] pin_in_p0,
  input wire logic [7:0] pin_in_p1,
  input wire logic [1:0] pin_in_p2,
  // Pad controls
  output pio_pad_t pad_p0,
  output pio_pad_t pad_p1,
  output pio_pad_t pad_p2
);
  // Elaboration guard: the divider counter is 16 bits wide, and a half period of
  // zero cycles would leave no flat part in the carrier at all
  localparam int PIO_DIV_MAX = 65535;
  if (HALF_CYCLES < 1 || HALF_CYCLES > PIO_DIV_MAX) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  logic [7:0] first_port_data_q, second_port_data_q, third_port_data_q;
  logic [7:0] carrier_pin_select_q;
  logic [7:0] pu_dis0_q, pu_dis1_q, pu_dis2_q;
  logic [15:0] div_q;
  logic carrier_q;
  logic [7:0] rdata_d;

  // One decode per register, shared by the write processes
  logic hit_p0, hit_p1, hit_p2, hit_csel, hit_pu0, hit_pu1, hit_pu2;

  // Address match; one function so every decode compares the same way
  function automatic logic pio_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : pio_hit

  // Register decode of the bus address
  always_comb begin
    hit_p0 = pio_hit(bus.addr, PIO_ADDR_PORT0);
    hit_p1 = pio_hit(bus.addr, PIO_ADDR_PORT1);
    hit_p2 = pio_hit(bus.addr, PIO_ADDR_PORT2);
    hit_csel = pio_hit(bus.addr, PIO_ADDR_CARRIER_SEL);
    hit_pu0 = pio_hit(bus.addr, PIO_ADDR_PU0);
    hit_pu1 = pio_hit(bus.addr, PIO_ADDR_PU1);
    hit_pu2 = pio_hit(bus.addr, PIO_ADDR_PU2);
  end

  // Merge a byte write or a single-bit write into a latch
  function automatic logic [7:0] pio_merge(input logic [7:0] cur, input pio_bus_req_t r);
    logic [7:0] m;
    m = cur;
    if (r.wr_byte) begin
      m = r.wdata;
    end else if (r.wr_bit) begin
      m[r.bit_sel] = r.wdata[0];
    end
    return m;
  endfunction : pio_merge

  // Pad drive of one pin; strong high never when open-drain
  function automatic logic [2:0] pio_pad(input logic lvl, input logic pu_dis,
                                         input logic own, input logic pout);
    logic v;
    v = own ? pout : lvl;
    // {out, oe, pu_en}: 0 drives low, 1 leaves only the weak pull-up or floats
    return {1'b0, ~v, ~pu_dis & v};
  endfunction : pio_pad

  // Port 0 latch; a read-modify-write sees this byte, not the pins, so an
  // input pin held low outside is not turned into a stuck low output
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_port_data_q <= PIO_RST_PORT;
    end else if (hit_p0) begin
      first_port_data_q <= pio_merge(first_port_data_q, bus);
    end
  end

  // Port 1 latch; byte and bit writes alike
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_port_data_q <= PIO_RST_PORT;
    end else if (hit_p1) begin
      second_port_data_q <= pio_merge(second_port_data_q, bus);
    end
  end

  // Port 2 latch; the six spare bits are forced set on every write, so they
  // cost flops but keep the read-latch path free of special cases
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      third_port_data_q <= PIO_RST_PORT;
    end else if (hit_p2) begin
      third_port_data_q <= pio_merge(third_port_data_q, bus) | PIO_PORT2_UNUSED;
    end
  end

  // Carrier select byte; byte writes only, a bit write is ignored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_pin_select_q <= PIO_RST_CFG;
    end else if (bus.wr_byte && hit_csel) begin
      carrier_pin_select_q <= bus.wdata;
    end
  end

  // Port 0 pull-up disables; a set bit turns the pin open-drain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pu_dis0_q <= PIO_RST_CFG;
    end else if (bus.wr_byte && hit_pu0) begin
      pu_dis0_q <= bus.wdata;
    end
  end

  // Port 1 pull-up disables
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pu_dis1_q <= PIO_RST_CFG;
    end else if (bus.wr_byte && hit_pu1) begin
      pu_dis1_q <= bus.wdata;
    end
  end

  // Port 2 pull-up disables; bits 7:2 are stored and read back but steer no pad
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pu_dis2_q <= PIO_RST_CFG;
    end else if (bus.wr_byte && hit_pu2) begin
      pu_dis2_q <= bus.wdata;
    end
  end

  // Carrier square wave from a fixed divider; held low while disabled to save power.
  // The divider restarts from zero on every enable, so the first edge always
  // comes a full half period after the enable rises; the half period is rounded
  // down, so the carrier runs a little fast at clock rates that do not divide
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 16'h0000;
      carrier_q <= 1'b0;
    end else if (!carrier_global_enable) begin
      div_q <= 16'h0000;
      carrier_q <= 1'b0;
    end else if (div_q == 16'(HALF_CYCLES - 1)) begin
      div_q <= 16'h0000;
      carrier_q <= ~carrier_q;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Effective levels with modulation XORed on selected pins.
  // A latched 1 under the carrier inverts the wave; a latched 0 passes it.
  // Port 2 has no carrier pin, so its latch feeds the pads directly
  logic [7:0] lvl0, lvl1;
  logic mod_on;
  always_comb begin
    mod_on = carrier_global_enable & carrier_q;
    lvl0 = first_port_data_q;
    lvl1 = second_port_data_q;
    lvl1[6] = lvl1[6] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P1_6]);
    lvl1[5] = lvl1[5] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P1_5]);
    lvl1[4] = lvl1[4] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P1_4]);
    lvl1[1] = lvl1[1] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P1_1]);
    lvl0[2] = lvl0[2] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P0_2]);
    lvl0[7] = lvl0[7] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P0_7]);
    lvl0[5] = lvl0[5] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P0_5]);
    lvl0[3] = lvl0[3] ^ (mod_on & carrier_pin_select_q[PIO_CSEL_P0_3]);
  end

  // Pad controls per pin; port 2 has only two pins, upper pads stay off.
  // A pin owned by a peripheral follows the peripheral level instead of the
  // latch and the carrier, under the same pull-up and open-drain rules
  always_comb begin
    pad_p0 = '0;
    pad_p1 = '0;
    pad_p2 = '0;
    for (int i = 0; i < 8; i++) begin
      {pad_p0.out[i], pad_p0.oe[i], pad_p0.pu_en[i]} =
        pio_pad(lvl0[i], pu_dis0_q[i], periph_own_p0[i], periph_out_p0[i]);
      {pad_p1.out[i], pad_p1.oe[i], pad_p1.pu_en[i]} =
        pio_pad(lvl1[i], pu_dis1_q[i], periph_own_p1[i], periph_out_p1[i]);
    end
    for (int i = 0; i < PIO_PORT2_BITS; i++) begin
      {pad_p2.out[i], pad_p2.oe[i], pad_p2.pu_en[i]} =
        pio_pad(third_port_data_q[i], pu_dis2_q[i], periph_own_p2[i], periph_out_p2[i]);
    end
  end

  // Read mux: read-modify-write reads the latch, others the pins.
  // Unmapped addresses read as zero; the pin path of port 2 pads the spare
  // bits with ones to match the latch path
  always_comb begin
    rdata_d = 8'h00;
    case (bus.addr)
      PIO_ADDR_PORT0: rdata_d = bus.rd_latch ? first_port_data_q : pin_in_p0;
      PIO_ADDR_PORT1: rdata_d = bus.rd_latch ? second_port_data_q : pin_in_p1;
      PIO_ADDR_PORT2: rdata_d = bus.rd_latch ? third_port_data_q : {6'h3f, pin_in_p2};
      PIO_ADDR_CARRIER_SEL: rdata_d = carrier_pin_select_q;
      PIO_ADDR_PU0: rdata_d = pu_dis0_q;
      PIO_ADDR_PU1: rdata_d = pu_dis1_q;
      PIO_ADDR_PU2: rdata_d = pu_dis2_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the read strobe; it holds between
  // reads so the CPU may take it late without a second strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= rdata_d;
    end
  end
endmodule : pio_ports

// ### pio_ports_props.sv
/* Checker for pio_ports: read paths, port 1 pads and carrier timing.
   Assumes port 1 is never owned by a peripheral. */
`timescale 1ns/10ps
module pio_ports_props
  import pio_pkg::*;
#(
  parameter int HALF_CYCLES = PIO_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pio_bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic carrier_global_enable,
  input wire logic [7:0] pin_in_p1,
  input wire pio_pad_t pad_p1
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Carrier phase since the enable rose; visible carrier edges land on phase 0
  logic [15:0] phase_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) phase_q <= 16'h0000;
    else if (!carrier_global_enable) phase_q <= 16'h0000;
    else if (phase_q == 16'(HALF_CYCLES - 1)) phase_q <= 16'h0000;
    else phase_q <= phase_q + 16'h0001;
  end
  // Read sources
  rd_latch_a: assert property (bus.wr_byte && bus.addr == 8'h80 ##1 bus.rd && bus.rd_latch
    && bus.addr == 8'h80 |=> rdata == $past(bus.wdata, 2)) else $error("latch read wrong");
  rd_pin_a: assert property (bus.rd && !bus.rd_latch && bus.addr == 8'h90
    |=> rdata == $past(pin_in_p1)) else $error("pin read wrong");
  unmapped_rd_a: assert property (bus.rd && bus.addr == 8'h42 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  port2_ones_a: assert property (bus.rd && bus.addr == 8'ha0 |=> rdata[7:2] == 6'h3f)
    else $error("port 2 spare bits not set");
  // Pads never drive high, and never sink with the pull-up on
  drive_low_a: assert property (pad_p1.out == 8'h00 && (pad_p1.oe & pad_p1.pu_en) == 8'h00)
    else $error("pad drives high");
  reset_pullup_a: assert property ($rose(rstn) |-> pad_p1.pu_en == 8'hff && pad_p1.oe == 8'h00)
    else $error("pads wrong after reset");
  pullup_dis_a: assert property (bus.wr_byte && bus.addr == 8'hb3 |=>
    (pad_p1.pu_en & ~pad_p1.oe) == (~$past(bus.wdata) & ~pad_p1.oe)) else $error("pull-up wrong");
  // Carrier: edges only on phase 0, so the next edge comes a half period later
  carrier_period_a: assert property (carrier_global_enable && $changed(pad_p1.oe[6]) && !$past(bus.wr_byte)
    && !$past(bus.wr_bit) |-> phase_q == 16'h0000) else $error("carrier period wrong");
  carrier_gate_a: assert property (!carrier_global_enable ##1 !carrier_global_enable && !bus.wr_byte
    && !bus.wr_bit |=> $stable(pad_p1)) else $error("pad moved while carrier off");
  cover property (bus.rd && !bus.rd_latch);
  cover property (carrier_global_enable && $changed(pad_p1.oe[6]));
  cover property (bus.wr_byte && bus.addr == 8'hb3);
endmodule : pio_ports_props
bind pio_ports pio_ports_props #(.HALF_CYCLES(HALF_CYCLES)) u_props (.ref_clk(ref_clk), .rstn(rstn),
  .bus(bus), .rdata(rdata), .carrier_global_enable(carrier_global_enable), .pin_in_p1(pin_in_p1), .pad_p1(pad_p1));

// ### pio_pin_model.sv
/* External devices on one port: resolves pads against outside drivers.
   Assumes pads settle after rising clock edges. */
`timescale 1ns/10ps
module pio_pin_model
  import pio_pkg::*;
(
  input wire logic ref_clk,
  input wire pio_pad_t pad,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] float_q = 8'h55;
  // A floating pin wanders, so a missing pull-up never reads as a clean level
  always_ff @(posedge ref_clk) float_q <= ~float_q;
  // Sink wins, then an outside driver, then the weak pull-up
  assign pin = ~pad.oe & ((ext_en & ext_val) | (~ext_en & (pad.pu_en | float_q)));
endmodule : pio_pin_model

// ### tb_parallel_io_ports_mod38.sv
/* Bench for pio_ports: register rows, bit writes, pin reads, carrier, reset.
   Assumes pio_pkg, the checker and the pin model are compiled first. */
`timescale 1ns/10ps
module tb_parallel_io_ports_mod38;
  import pio_pkg::*;
  logic ref_clk = 0, rstn, cge, p;
  pio_bus_req_t bus;
  logic [7:0] rdata, own0, out0, ext_en, ext_val, pin0, pin1;
  logic [1:0] own2, out2, pin2;
  pio_pad_t pad0, pad1, pad2;
  int mismatches = 0, n_checks = 0, tg = 0;
  // Address, write data, expected latch read
  logic [23:0] rows [8] = '{24'h805b5b, 24'h900000, 24'ha000fc, 24'h9f8181, 24'hb20f0f, 24'hb30000,
    24'hb4ffff, 24'h425500};
  pio_ports #(.HALF_CYCLES(4)) uut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .carrier_global_enable(cge), .periph_own_p0(own0), .periph_own_p1(8'h00), .periph_own_p2(own2),
    .periph_out_p0(out0), .periph_out_p1(8'h00), .periph_out_p2(out2), .pin_in_p0(pin0), .pin_in_p1(pin1),
    .pin_in_p2(pin2), .pad_p0(pad0), .pad_p1(pad1), .pad_p2(pad2));
  pio_pin_model m0 (.ref_clk(ref_clk), .pad(pad0), .ext_en(8'h00), .ext_val(8'h00), .pin(pin0));
  pio_pin_model m1 (.ref_clk(ref_clk), .pad(pad1), .ext_en(ext_en), .ext_val(ext_val), .pin(pin1));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bus tasks start at a falling edge and leave the request up for the next one to replace
  task automatic wr(logic [7:0] a, logic [7:0] d, logic bw = 0, logic [2:0] s = 0);
    bus = '{a, d, !bw, bw, s, 1'b0, 1'b0};
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic l);
    bus = '{a, 8'h00, 1'b0, 1'b0, 3'h0, 1'b1, l};
    @(negedge ref_clk);
  endtask : rd
  task automatic idle;
    bus = '0;
    @(negedge ref_clk);
  endtask : idle
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Clock
  initial forever #5 ref_clk = ~ref_clk;
  // Watchdog at 2000 cycles, far beyond the roughly 65 cycles the run needs
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
  // Main sequence
  initial begin
    bus = '0;
    {rstn, cge, own0, out0, ext_en, ext_val, own2, out2} = '0;
    pin2 = 2'h3;
    repeat (3) @(negedge ref_clk);
    rstn = 1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 1'b1);
      chk(rdata, rows[i][7:0]);
    end
    wr(8'h80, 8'h00, 1'b1, 3'h3);
    wr(8'hb2, 8'h00, 1'b1, 3'h0);
    rd(8'h80, 1'b1);
    chk(rdata, 8'h53);
    rd(8'hb2, 1'b1);
    chk(rdata, 8'h0f);
    // Carrier on P1.6 over a latched 0, stopped just after an edge
    cge = 1;
    idle;
    p = pad1.oe[6];
    repeat (24) begin
      @(negedge ref_clk);
      if (pad1.oe[6] !== p) tg++;
      p = pad1.oe[6];
    end
    chk({7'h0, tg >= 4}, 8'h01);
    while (pad1.oe[6] === p) @(negedge ref_clk);
    cge = 0;
    repeat (3) @(negedge ref_clk);
    chk(pad1.oe, 8'hff);
    // Pin against latch on port 1, pull-ups off on all eight pins
    wr(8'h90, 8'h0f);
    wr(8'hb3, 8'hff);
    ext_en = 8'h0f;
    ext_val = 8'h05;
    rd(8'h90, 1'b0);
    chk(rdata, 8'h05);
    rd(8'h90, 1'b1);
    chk(rdata, 8'h0f);
    chk(pad1.oe, 8'hf0);
    chk(pad1.pu_en, 8'h00);
    own0 = 8'h01;
    idle;
    chk(pad0.oe, 8'had);
    rstn = 0;
    idle;
    rstn = 1;
    rd(8'h9f, 1'b1);
    chk(rdata, 8'h00);
    rd(8'ha0, 1'b1);
    chk(rdata, 8'hff);
    chk(pad1.pu_en, 8'hff);
    chk(pad2.pu_en, 8'h03);
    own2 = 2'h1;
    pin2 = 2'h1;
    rd(8'ha0, 1'b0);
    chk(rdata, 8'hfd);
    chk(pad2.oe, 8'h01);
    final_report;
  end
endmodule : tb_parallel_io_ports_mod38
